// >>> bench/interrupt_aggregation_tree_properties.sv
// concurrent checks on the tree's ports
// assumes bind onto the top module
module irq_tree_checker
  import irq_tree_pkg::*;
(
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_clk_en,
  input wire logic                   i_wb_cyc,
  input wire logic                   i_wb_stb,
  input wire logic [N_LAT*SRC_W-1:0] i_events,
  input wire logic [31:0]            o_wb_dat,
  input wire logic                   o_wb_ack,
  input wire logic [GLB_W-1:0]       o_global_summary,
  input wire logic                   o_irq_n_out,
  input wire logic                   o_irq_n_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_oe_on_irq: assert property (!o_irq_n_out |-> o_irq_n_oe)
    else $error("pin not driven while interrupt pending");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> o_irq_n_out && o_global_summary == 4'h0)
    else $error("interrupt or summary up out of reset");
  a_line_event: assert property (i_clk_en && |i_events[7:0] |=> o_global_summary[BIT_LINE])
    else $error("line summary missed an event");
  a_no_spurious: assert property (o_irq_n_out && !(|i_events) && !(i_wb_cyc && i_wb_stb)
    |=> o_irq_n_out)
    else $error("interrupt without cause");
  a_summary_fall: assert property ($fell(o_global_summary[BIT_LINE])
    |-> $past(i_wb_cyc && i_wb_stb))
    else $error("summary dropped without host access");
  a_irq_release: assert property ($rose(o_irq_n_out) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("interrupt released without host access");
  a_ack_answer: assert property (i_clk_en && i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not one cycle after request");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
endmodule // irq_tree_checker

bind interrupt_aggregation_tree irq_tree_checker u_chk (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_events(i_events), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_global_summary(o_global_summary), .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe));

// >>> bench/irq_host_model.sv
// host side of the interrupt pin, with a pull-up
// assumes the tree drives the pin only while oe is high
module irq_host_model (
  input  wire logic i_irq_n_out,
  input  wire logic i_irq_n_oe,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_pin = i_irq_n_oe ? i_irq_n_out : 1'b1;
endmodule // irq_host_model

// >>> bench/test_interrupt_aggregation_tree.sv
// self-checking bench for the interrupt aggregation tree
// assumes a pull-up on the pin, given by the host model
module test_interrupt_aggregation_tree;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_tree_pkg::*;
  logic                   i_sys_clk = 1'b0;
  logic                   i_rst_n   = 1'b0;
  logic                   i_clk_en  = 1'b1;
  wb_req_t                req       = '0;
  logic [N_LAT*SRC_W-1:0] ev        = '0;
  logic [31:0]            o_wb_dat;
  logic [31:0]            rdat;
  logic [GLB_W-1:0]       o_global_summary;
  logic                   o_wb_ack, o_irq_n_out, o_irq_n_oe, pin;
  int                     miscompares = 0;
  int                     checks_done = 0;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
  initial forever #2 i_sys_clk = ~i_sys_clk;
  interrupt_aggregation_tree DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_wb_cyc(req.cyc), .i_wb_stb(req.stb), .i_wb_we(req.we), .i_wb_sel(req.sel),
    .i_wb_adr(req.adr), .i_wb_dat(req.dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_events(ev), .o_global_summary(o_global_summary), .o_irq_n_out(o_irq_n_out),
    .o_irq_n_oe(o_irq_n_oe));
  irq_host_model host (.i_irq_n_out(o_irq_n_out), .i_irq_n_oe(o_irq_n_oe), .o_pin(pin));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    rdat = o_wb_dat;
    req <= '0;
    if (n >= 50) begin
      miscompares++;
      print_verdict();
    end
    @(negedge i_sys_clk);
  endtask
  task automatic pulse(input int g, input int b);
    @(posedge i_sys_clk);
    ev[8*g+b] <= 1'b1;
    @(posedge i_sys_clk);
    ev <= '0;
    @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge i_sys_clk);
    `CHK({o_irq_n_out, o_irq_n_oe}, 2'b10)
    i_rst_n <= 1'b1;
    bus(0, OFF_GLOBAL_ENABLE, 0);
    `CHK(rdat, 32'h0)
    bus(0, OFF_READ_CLEAR_ENABLE, 0);
    `CHK(rdat, 32'h1)
    bus(0, 8'h60, 0);
    `CHK(rdat, 32'h0)
    $display("test done: reset values");
    pulse(L_TQC, 3);
    `CHK(o_global_summary, 4'h1)
    `CHK(pin, 1'b1)
    bus(1, OFF_GLOBAL_ENABLE, 32'h1);
    `CHK(pin, 1'b0)
    bus(1, OFF_TX_QUEUE_CTRL_LATCHED, 32'h0);
    `CHK(pin, 1'b0)
    bus(0, OFF_GLOBAL_SUMMARY, 0);
    `CHK(rdat, 32'h1)
    bus(1, OFF_TX_QUEUE_CTRL_LATCHED, 32'h8);
    `CHK({pin, o_global_summary}, 5'h10)
    $display("test done: write one to clear");
    bus(1, OFF_GLOBAL_ENABLE, 32'hF);
    pulse(L_BER, 0);
    `CHK({pin, o_global_summary}, 5'h10)
    bus(0, OFF_BIT_ERROR_TEST_LATCHED, 0);
    `CHK(rdat, 32'h1)
    bus(0, OFF_BIT_ERROR_TEST_LATCHED, 0);
    `CHK(rdat, 32'h0)
    $display("test done: disabled source");
    bus(1, OFF_QUEUE_CTRL_ENABLE, 32'h1);
    pulse(L_QC, 7);
    `CHK({pin, o_global_summary}, 5'h03)
    bus(0, OFF_QUEUE_CTRL_LATCHED, 0);
    `CHK(rdat, 32'h80)
    `CHK({pin, o_global_summary}, 5'h10)
    pulse(L_QC, 0);
    `CHK({pin, o_global_summary}, 5'h10)
    bus(0, OFF_QUEUE_CTRL_LATCHED, 0);
    `CHK(rdat, 32'h1)
    $display("test done: queue control order");
    bus(1, OFF_TX_PACKET_PROC_ENABLE, 32'h4);
    pulse(L_TPP, 2);
    `CHK({pin, o_global_summary}, 5'h09)
    bus(0, OFF_TX_PACKET_PROC_LATCHED, 0);
    `CHK({pin, o_global_summary}, 5'h10)
    bus(1, OFF_GLOBAL_CONTROL_ONE, 32'h1);
    `CHK({o_irq_n_out, o_irq_n_oe}, 2'b11)
    $display("test done: queue summary and idle drive");
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    pulse(L_TQC, 0);
    `CHK({pin, o_global_summary}, 5'h10)
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    pulse(L_TQC, 0);
    `CHK({pin, o_global_summary}, 5'h01)
    bus(0, OFF_TX_QUEUE_CTRL_LATCHED, 0);
    `CHK(rdat, 32'h1)
    $display("test done: clock enable freeze");
    print_verdict();
  end
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
endmodule // test_interrupt_aggregation_tree

// >>> rtl/interrupt_aggregation_tree.sv
// two-level interrupt aggregation tree with wishbone register slave
// assumes event inputs are one-cycle pulses synchronous to i_sys_clk
//
// Functional notes
// - each summary bit collects a fixed group of latched registers; groups overlap and bond registers are in none.
// - summary bits are real-time, dropping once no enabled latched bit remains.
// - writing one to a latched bit clears it; host clears serviced conditions.
// - latched bit passes upward only when its individual enable is one; tx queue control latched bits always pass.
// - enable zero blocks propagation only; latched bits still set on events.
// - control bit selects interrupt idle state: released or actively driven.
// - reading a latched register clears every bit of it while read-clear enable is one.
// - no interrupt generated while device reset is active.
// - global enable zero blocks that summary bit from the interrupt output.
// - after all latched causes are read with read-clear enable one, summary and interrupt drop.
// - queue control enable uses different bit order, mapped by function.
module interrupt_aggregation_tree
  import irq_tree_pkg::*;
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [ADR_W-1:0]        i_wb_adr,
  input  wire logic [31:0]             i_wb_dat,
  output logic      [31:0]             o_wb_dat,
  output logic                         o_wb_ack,
  input  wire logic [N_LAT*SRC_W-1:0]  i_events,
  output logic      [GLB_W-1:0]        o_global_summary,
  output logic                         o_irq_n_out,
  output logic                         o_irq_n_oe
);

  irq_state_t state_reg;
  irq_state_t state_next;
  wb_req_t    req;
  lat_arr_t   ev;
  lat_arr_t   eff_en;
  logic [N_LAT-1:0] pend;
  logic [GLB_W-1:0] summary;
  logic             irq;
  logic             hit;
  logic             wr;
  logic             rd;

  assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                 adr: i_wb_adr, dat: i_wb_dat};
  assign ev  = lat_arr_t'(i_events);

  // enable bit i of queue control guards latched bit SRC_W-1-i
  function automatic logic [SRC_W-1:0] reverse_bits(input logic [SRC_W-1:0] v);
    logic [SRC_W-1:0] r;
    for (int i = 0; i < SRC_W; i++) begin
      r[i] = v[SRC_W-1-i];
    end
    return r;
  endfunction

  // index of a latched register at a byte address, N_LAT when none
  function automatic logic [3:0] lat_index(input logic [ADR_W-1:0] a);
    logic [3:0] r;
    r = 4'(N_LAT);
    if (a < OFF_TX_PACKET_PROC_ENABLE && a[1:0] == 2'b00) begin
      r = a[5:2];
    end
    return r;
  endfunction

  // index of an enable register, N_LAT when none; tx-queue-ctrl-latched has none
  function automatic logic [3:0] en_index(input logic [ADR_W-1:0] a);
    logic [3:0] r;
    r = 4'(N_LAT);
    unique case (a)
      OFF_TX_PACKET_PROC_ENABLE: r = 4'(L_TPP);
      OFF_RX_PACKET_PROC_ENABLE: r = 4'(L_RPP);
      OFF_RX_LAPS_ENABLE:        r = 4'(L_LAP);
      OFF_QUEUE_CTRL_ENABLE:     r = 4'(L_QC);
      OFF_BIT_ERROR_TEST_ENABLE: r = 4'(L_BER);
      OFF_BOND_SYNC_ENABLE:      r = 4'(L_BSY);
      OFF_BOND_DELAY_ENABLE:     r = 4'(L_BDL);
      OFF_BOND_FRAMELOSS_ENABLE: r = 4'(L_BFL);
      default:                   r = 4'(N_LAT);
    endcase
    return r;
  endfunction

  always_comb begin
    for (int k = 0; k < N_LAT; k++) begin
      eff_en[k] = state_reg.enable[k];
    end
    eff_en[L_QC] = reverse_bits(state_reg.enable[L_QC]);
    // tx queue control latched has no own enable register: always passes
    eff_en[L_TQC] = {SRC_W{1'b1}};
    for (int k = 0; k < N_LAT; k++) begin
      pend[k] = |(state_reg.latched[k] & eff_en[k]);
    end
    // group membership per summary bit
    summary[BIT_QUEUE] = pend[L_TPP] | pend[L_RPP];
    summary[BIT_LINE]  = pend[L_TQC] | pend[L_TPP] | pend[L_RPP] | pend[L_LAP] |
                         pend[L_QC];
    summary[BIT_SYS]   = pend[L_QC];
    summary[BIT_BERT]  = pend[L_BER];
    // bond registers each sit behind their own per-bit enable register only, not the global enable
    irq = |(summary & state_reg.glb_enable) |
          pend[L_BSY] | pend[L_BDL] | pend[L_BFL];
  end

  always_comb begin
    logic [3:0]  li;
    logic [3:0]  ei;
    logic [31:0] wmask;
    li    = lat_index(req.adr);
    ei    = en_index(req.adr);
    wmask = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
    hit   = req.cyc & req.stb & ~state_reg.ack;
    wr    = hit & req.we;
    rd    = hit & ~req.we;
    state_next       = state_reg;
    state_next.ack   = hit;
    state_next.rdata = 32'h0000_0000;
    // host writes and read-clears, then new events win over any clear
    if (wr && li != 4'(N_LAT)) begin
      state_next.latched[li] = state_reg.latched[li] &
                               ~(req.dat[SRC_W-1:0] & wmask[SRC_W-1:0]);
    end
    if (rd && li != 4'(N_LAT)) begin
      state_next.rdata = 32'(state_reg.latched[li]);
      if (state_reg.rd_clear) begin
        state_next.latched[li] = RST_LATCHED;
      end
    end
    if (wr && ei != 4'(N_LAT) && req.sel[0]) begin
      state_next.enable[ei] = req.dat[SRC_W-1:0];
    end
    if (rd && ei != 4'(N_LAT)) begin
      state_next.rdata = 32'(state_reg.enable[ei]);
    end
    if (req.adr == OFF_GLOBAL_ENABLE) begin
      if (wr && req.sel[0]) begin
        state_next.glb_enable = req.dat[GLB_W-1:0];
      end
      if (rd) begin
        state_next.rdata = 32'(state_reg.glb_enable);
      end
    end
    if (req.adr == OFF_GLOBAL_SUMMARY && rd) begin
      state_next.rdata = 32'(summary);
    end
    if (req.adr == OFF_GLOBAL_CONTROL_ONE) begin
      if (wr && req.sel[0]) begin
        state_next.idle_drive = req.dat[BIT_IRQ_IDLE_DRIVE];
      end
      if (rd) begin
        state_next.rdata = 32'(state_reg.idle_drive);
      end
    end
    if (req.adr == OFF_READ_CLEAR_ENABLE) begin
      if (wr && req.sel[0]) begin
        state_next.rd_clear = req.dat[0];
      end
      if (rd) begin
        state_next.rdata = 32'(state_reg.rd_clear);
      end
    end
    for (int k = 0; k < N_LAT; k++) begin
      state_next.latched[k] = state_next.latched[k] | ev[k];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg.latched    <= '0;
      state_reg.enable     <= '0;
      state_reg.glb_enable <= RST_GLB_ENABLE;
      state_reg.idle_drive <= RST_IDLE_DRV;
      state_reg.rd_clear   <= RST_RD_CLEAR;
      state_reg.ack        <= 1'b0;
      state_reg.rdata      <= 32'h0000_0000;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  assign o_wb_ack         = state_reg.ack;
  assign o_wb_dat         = state_reg.rdata;
  assign o_global_summary = summary;
  // active-low pin: driven low on interrupt, idle released or driven high
  assign o_irq_n_out = ~(irq & i_rst_n);
  assign o_irq_n_oe  = (irq & i_rst_n) | (state_reg.idle_drive & i_rst_n);

endmodule // interrupt_aggregation_tree

// >>> rtl/irq_tree_pkg.sv
// package of the interrupt aggregation tree: register map, field layout, types
// assumes a 32-bit classic wishbone bus with word addressing by byte address
package irq_tree_pkg;

  localparam int unsigned SRC_W = 8;
  localparam int unsigned ADR_W = 8;

  // register byte offsets
  localparam logic [ADR_W-1:0] OFF_TX_QUEUE_CTRL_LATCHED  = 8'h00;
  localparam logic [ADR_W-1:0] OFF_TX_PACKET_PROC_LATCHED = 8'h04;
  localparam logic [ADR_W-1:0] OFF_RX_PACKET_PROC_LATCHED = 8'h08;
  localparam logic [ADR_W-1:0] OFF_RX_LAPS_STATUS         = 8'h0C;
  localparam logic [ADR_W-1:0] OFF_QUEUE_CTRL_LATCHED     = 8'h10;
  localparam logic [ADR_W-1:0] OFF_BIT_ERROR_TEST_LATCHED = 8'h14;
  localparam logic [ADR_W-1:0] OFF_BOND_SYNC_LATCHED      = 8'h18;
  localparam logic [ADR_W-1:0] OFF_BOND_DELAY_LATCHED     = 8'h1C;
  localparam logic [ADR_W-1:0] OFF_BOND_FRAMELOSS_LATCHED = 8'h20;
  localparam logic [ADR_W-1:0] OFF_TX_PACKET_PROC_ENABLE  = 8'h24;
  localparam logic [ADR_W-1:0] OFF_RX_PACKET_PROC_ENABLE  = 8'h28;
  localparam logic [ADR_W-1:0] OFF_RX_LAPS_ENABLE         = 8'h2C;
  localparam logic [ADR_W-1:0] OFF_QUEUE_CTRL_ENABLE      = 8'h30;
  localparam logic [ADR_W-1:0] OFF_BIT_ERROR_TEST_ENABLE  = 8'h34;
  localparam logic [ADR_W-1:0] OFF_BOND_SYNC_ENABLE       = 8'h38;
  localparam logic [ADR_W-1:0] OFF_BOND_DELAY_ENABLE      = 8'h3C;
  localparam logic [ADR_W-1:0] OFF_BOND_FRAMELOSS_ENABLE  = 8'h40;
  localparam logic [ADR_W-1:0] OFF_GLOBAL_SUMMARY         = 8'h44;
  localparam logic [ADR_W-1:0] OFF_GLOBAL_ENABLE          = 8'h48;
  localparam logic [ADR_W-1:0] OFF_GLOBAL_CONTROL_ONE     = 8'h4C;
  localparam logic [ADR_W-1:0] OFF_READ_CLEAR_ENABLE      = 8'h50;

  // global summary and global enable field positions
  localparam int unsigned BIT_LINE  = 0;
  localparam int unsigned BIT_SYS   = 1;
  localparam int unsigned BIT_BERT  = 2;
  localparam int unsigned BIT_QUEUE = 3;
  localparam int unsigned GLB_W     = 4;

  // global_control_one field positions
  localparam int unsigned BIT_IRQ_IDLE_DRIVE = 0;

  // reset values
  localparam logic [SRC_W-1:0] RST_LATCHED    = 8'h00;
  localparam logic [SRC_W-1:0] RST_ENABLE     = 8'h00;
  localparam logic [GLB_W-1:0] RST_GLB_ENABLE = 4'h0;
  localparam logic             RST_IDLE_DRV   = 1'b0;
  localparam logic             RST_RD_CLEAR   = 1'b1;

  // latched source registers, in map order
  localparam int unsigned N_LAT = 9;
  localparam int unsigned L_TQC = 0;
  localparam int unsigned L_TPP = 1;
  localparam int unsigned L_RPP = 2;
  localparam int unsigned L_LAP = 3;
  localparam int unsigned L_QC  = 4;
  localparam int unsigned L_BER = 5;
  localparam int unsigned L_BSY = 6;
  localparam int unsigned L_BDL = 7;
  localparam int unsigned L_BFL = 8;

  typedef logic [N_LAT-1:0][SRC_W-1:0] lat_arr_t;

  typedef struct packed {
    lat_arr_t          latched;
    lat_arr_t          enable;
    logic [GLB_W-1:0]  glb_enable;
    logic              idle_drive;
    logic              rd_clear;
    logic              ack;
    logic [31:0]       rdata;
  } irq_state_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADR_W-1:0]  adr;
    logic [31:0]       dat;
  } wb_req_t;

endpackage
